// ==== hdl/ppl_pkg.sv ====
package ppl_pkg;
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_EVENT  = 8'h08;
    localparam logic [7:0] REG_MASK   = 8'h0c;
    localparam logic [7:0] REG_DATA   = 8'h10;
    localparam logic [7:0] REG_WORDS  = 8'h14;
    localparam int CTRL_START  = 0;
    localparam int CTRL_WIDTH  = 1;
    localparam int CTRL_DECOMP = 3;
    localparam int CTRL_SECURE = 4;
    localparam int CTRL_ABORT  = 5;
    localparam int EV_DONE   = 0;
    localparam int EV_ERROR  = 1;
    localparam int EV_NEED   = 2;
    localparam logic [1:0] WIDTH_8  = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;
    localparam int CLK_DIV_HALF = 4;
    localparam int REQ_LOW_NS = 2000;
    localparam int SYS_PERIOD_NS = 20;
    localparam int REQ_LOW_CYC = (REQ_LOW_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int STATUS_TIMEOUT_DEFAULT = 100000;
    localparam int INIT_EDGES = 2;
    localparam logic [5:0] EV_RESET = 6'h00;
    localparam logic [31:0] WORDS_RESET = 32'h0000_0000;
endpackage

// ==== hdl/ppl_ratio.sv ====
`timescale 1ns/1ps
module ppl_ratio (
    // mode
    input  wire logic [1:0] width,
    input  wire logic       decomp,
    input  wire logic       secure,
    // clocks per word
    output logic      [3:0] ratio
);
    always_comb begin
        ratio = 4'h1;
        unique case (width)
            ppl_pkg::WIDTH_8: begin
                ratio = decomp ? 4'h2 : 4'h1;
            end
            ppl_pkg::WIDTH_16: begin
                ratio = decomp ? 4'h4 : (secure ? 4'h2 : 4'h1);
            end
            default: begin
                ratio = decomp ? 4'h8 : (secure ? 4'h4 : 4'h1);
            end
        endcase
    end
endmodule

// ==== hdl/ppl_host.sv ====
`timescale 1ns/1ps
module ppl_host #(
    parameter int STATUS_TIMEOUT = ppl_pkg::STATUS_TIMEOUT_DEFAULT
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rdata,
    output logic             irq,
    // device pins
    output logic             config_clock,
    output logic [31:0]      cfg_data,
    output logic             cfg_req_b,
    input  wire logic        cfg_status_b,
    input  wire logic        cfg_done,
    input  wire logic        init_done
);
    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_REQ   = 7'b0000010,
        ST_WAITS = 7'b0000100,
        ST_LOAD  = 7'b0001000,
        ST_TAIL  = 7'b0010000,
        ST_INIT  = 7'b0100000,
        ST_USER  = 7'b1000000
    } ppl_state_t;

    ppl_state_t  state_reg;
    logic [5:0]  ctrl_reg;
    logic [2:0]  ev_reg;
    logic [2:0]  mask_reg;
    logic [31:0] word_reg;
    logic        word_full_reg;
    logic [31:0] words_reg;
    logic [31:0] timer_reg;
    logic [3:0]  phase_reg;
    logic [2:0]  div_reg;
    logic        clk_reg;
    logic [2:0]  st_sync, dn_sync, in_sync;
    logic        status_q, done_q, init_q;
    logic [3:0]  ratio;
    logic        rise, fall;
    logic        data_wr;
    logic [2:0]  ev_set;

    ppl_ratio u_ratio (
        .width  (ctrl_reg[ppl_pkg::CTRL_WIDTH +: 2]),
        .decomp (ctrl_reg[ppl_pkg::CTRL_DECOMP]),
        .secure (ctrl_reg[ppl_pkg::CTRL_SECURE]),
        .ratio  (ratio)
    );

    // device pins are asynchronous; change counts once stages 2 and 3 agree
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_sync  <= 3'h0;
            dn_sync  <= 3'h0;
            in_sync  <= 3'h0;
            status_q <= 1'b0;
            done_q   <= 1'b0;
            init_q   <= 1'b0;
        end else begin
            st_sync <= {st_sync[1:0], cfg_status_b};
            dn_sync <= {dn_sync[1:0], cfg_done};
            in_sync <= {in_sync[1:0], init_done};
            if (st_sync[2] == st_sync[1]) begin
                status_q <= st_sync[2];
            end
            if (dn_sync[2] == dn_sync[1]) begin
                done_q <= dn_sync[2];
            end
            if (in_sync[2] == in_sync[1]) begin
                init_q <= in_sync[2];
            end
        end
    end

    // clock divider rises only while loading or finishing; a high phase already started always falls
    logic clk_run;
    assign clk_run = (state_reg == ST_LOAD && (word_full_reg || phase_reg != 4'h0)) ||
                     state_reg == ST_TAIL || state_reg == ST_INIT;
    assign rise = clk_run && div_reg == 3'(ppl_pkg::CLK_DIV_HALF - 1) && !clk_reg;
    assign fall = div_reg == 3'(ppl_pkg::CLK_DIV_HALF - 1) && clk_reg;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_reg <= 3'h0;
            clk_reg <= 1'b0;
        end else if (rise || fall) begin
            div_reg <= 3'h0;
            clk_reg <= !clk_reg;
        end else if (clk_run || clk_reg) begin
            div_reg <= div_reg + 3'h1;
        end else begin
            div_reg <= 3'h0; // pause holds clock low
        end
    end
    assign config_clock = clk_reg; // always driven, parks low

    assign data_wr = wr_en && addr == ppl_pkg::REG_DATA;

    // one-word holding register; software polls the status full bit for room
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            word_reg      <= 32'h0;
            word_full_reg <= 1'b0;
        end else if (data_wr && !word_full_reg) begin
            word_reg      <= wdata;
            word_full_reg <= 1'b1;
        end else if (state_reg == ST_LOAD && fall && phase_reg == ratio - 4'h1) begin
            word_full_reg <= 1'b0;
        end else if (state_reg == ST_IDLE || state_reg == ST_USER) begin
            word_full_reg <= 1'b0;
        end
    end

    // data set up before the rising edge, held for r clocks per word
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_data <= 32'h0;
        end else if (state_reg == ST_LOAD && phase_reg == 4'h0 && !clk_reg && word_full_reg) begin
            cfg_data <= word_reg; // full bus valid before first rise
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_reg <= 4'h0;
        end else if (state_reg == ST_LOAD || state_reg == ST_TAIL) begin
            if (fall) begin
                phase_reg <= (phase_reg == ratio - 4'h1) ? 4'h0 : phase_reg + 4'h1;
            end
        end else begin
            phase_reg <= 4'h0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            timer_reg <= 32'h0;
            words_reg <= ppl_pkg::WORDS_RESET;
            cfg_req_b <= 1'b1;
        end else begin
            unique case (state_reg)
                ST_IDLE, ST_USER: begin
                    cfg_req_b <= 1'b1;
                    if (wr_en && addr == ppl_pkg::REG_CTRL && wdata[ppl_pkg::CTRL_START]) begin
                        cfg_req_b <= 1'b0;
                        timer_reg <= 32'h0;
                        words_reg <= 32'h0;
                        state_reg <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    timer_reg <= timer_reg + 32'h1;
                    if (timer_reg >= 32'(ppl_pkg::REQ_LOW_CYC) && !status_q) begin
                        cfg_req_b <= 1'b1;
                        timer_reg <= 32'h0;
                        state_reg <= ST_WAITS;
                    end
                end
                ST_WAITS: begin
                    timer_reg <= timer_reg + 32'h1;
                    if (status_q) begin // device ends its reset delay
                        state_reg <= ST_LOAD;
                    end else if (timer_reg >= 32'(STATUS_TIMEOUT)) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_LOAD: begin
                    if (rise && phase_reg == 4'h0) begin
                        words_reg <= words_reg + 32'h1;
                    end
                    if (!status_q) begin
                        state_reg <= ST_IDLE;
                    end else if (done_q && phase_reg == 4'h0) begin
                        state_reg <= (ratio == 4'h1) ? ST_INIT : ST_TAIL;
                        timer_reg <= 32'h0;
                    end
                end
                ST_TAIL: begin
                    // r trailing clocks whenever r is above 1: decompress, or decrypt at 16 and 32 bits
                    if (fall && phase_reg == ratio - 4'h1) begin
                        state_reg <= ST_INIT;
                        timer_reg <= 32'h0;
                    end
                end
                ST_INIT: begin
                    if (fall) begin
                        timer_reg <= timer_reg + 32'h1;
                        if (timer_reg >= 32'(ppl_pkg::INIT_EDGES - 1)) begin
                            state_reg <= ST_USER;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
            if (wr_en && addr == ppl_pkg::REG_CTRL && wdata[ppl_pkg::CTRL_ABORT]) begin
                state_reg <= ST_IDLE;
                cfg_req_b <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= 6'h0;
        end else if (wr_en && addr == ppl_pkg::REG_CTRL && state_reg != ST_LOAD) begin
            ctrl_reg <= {1'b0, wdata[4:0] & 5'h1e};
        end
    end

    // sticky events: set wins over write-one-to-clear
    assign ev_set[ppl_pkg::EV_DONE]  = state_reg == ST_INIT && fall &&
                                       timer_reg >= 32'(ppl_pkg::INIT_EDGES - 1);
    assign ev_set[ppl_pkg::EV_ERROR] = (state_reg == ST_LOAD && !status_q) ||
                                       (state_reg == ST_WAITS && !status_q &&
                                        timer_reg >= 32'(STATUS_TIMEOUT));
    assign ev_set[ppl_pkg::EV_NEED]  = state_reg == ST_LOAD && !word_full_reg;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_reg   <= 3'h0;
            mask_reg <= 3'h0;
        end else begin
            if (wr_en && addr == ppl_pkg::REG_EVENT) begin
                ev_reg <= (ev_reg & ~wdata[2:0]) | ev_set;
            end else begin
                ev_reg <= ev_reg | ev_set;
            end
            if (wr_en && addr == ppl_pkg::REG_MASK) begin
                mask_reg <= wdata[2:0];
            end
        end
    end
    assign irq = |(ev_reg & mask_reg);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 32'h0;
        end else if (rd_en) begin
            unique case (addr)
                ppl_pkg::REG_CTRL:   rdata <= {26'h0, ctrl_reg};
                ppl_pkg::REG_STATUS: rdata <= {17'h0, ratio, state_reg, word_full_reg,
                                               init_q, done_q, status_q};
                ppl_pkg::REG_EVENT:  rdata <= {29'h0, ev_reg};
                ppl_pkg::REG_MASK:   rdata <= {29'h0, mask_reg};
                ppl_pkg::REG_WORDS:  rdata <= words_reg;
                default:             rdata <= 32'h0;
            endcase
        end else begin
            rdata <= 32'h0;
        end
    end
endmodule

// ==== tb/ppl_host_sva.sv ====
`timescale 1ns/1ps
module ppl_host_sva #(
    parameter int STATUS_TIMEOUT = ppl_pkg::STATUS_TIMEOUT_DEFAULT
) (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_b,
    // register port
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [31:0] rdata,
    input wire logic        irq,
    // device pins
    input wire logic        config_clock,
    input wire logic [31:0] cfg_data,
    input wire logic        cfg_req_b,
    input wire logic        cfg_status_b,
    input wire logic        cfg_done,
    input wire logic        init_done
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    int   req_cnt;
    logic seen_low;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            req_cnt  <= 0;
            seen_low <= 1'b0;
        end else if (cfg_req_b) begin
            req_cnt  <= 0;
            seen_low <= 1'b0;
        end else begin
            req_cnt  <= req_cnt + 1;
            seen_low <= seen_low | !cfg_status_b;
        end
    end
    AST_CLK_HIGH: assert property ($rose(config_clock) |-> config_clock [*4] ##1 !config_clock)
        else $error("clock high phase not four cycles");
    AST_CLK_LOW: assert property ($fell(config_clock) |-> !config_clock [*4])
        else $error("clock low phase too short");
    AST_DATA_HOLD: assert property (config_clock |-> $stable(cfg_data))
        else $error("data moved while clock high");
    AST_REQ_LEN: assert property ($rose(cfg_req_b) |-> req_cnt >= ppl_pkg::REQ_LOW_CYC)
        else $error("request low too short");
    AST_REQ_STATUS: assert property ($rose(cfg_req_b) |-> seen_low)
        else $error("request released before status low");
    AST_NO_CLK_REQ: assert property (!cfg_req_b |-> !$rose(config_clock))
        else $error("clock edge during request");
    AST_DONE_TAIL: assert property ($rose(cfg_done) |-> ##[1:300] $fell(config_clock))
        else $error("no falling edges after complete");
    AST_RDATA_IDLE: assert property (!$past(rd_en) |-> rdata == 32'h0000_0000)
        else $error("read data outside read slot");
    cover property ($rose(cfg_done));
    cover property ($rose(cfg_req_b));
    cover property ($rose(irq));
endmodule

bind ppl_host ppl_host_sva #(.STATUS_TIMEOUT(STATUS_TIMEOUT)) u_sva (
    .sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .irq(irq), .config_clock(config_clock),
    .cfg_data(cfg_data), .cfg_req_b(cfg_req_b), .cfg_status_b(cfg_status_b),
    .cfg_done(cfg_done), .init_done(init_done));

// ==== tb/ppl_dev_model.sv ====
`timescale 1ns/1ps
module ppl_dev_model #(
    parameter int WORDS   = 2,
    parameter int POR_DLY = 20
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // pins from the host
    input  wire logic        config_clock,
    input  wire logic [31:0] cfg_data,
    input  wire logic        cfg_req_b,
    // scenario control
    input  wire logic [3:0]  ratio,
    input  wire logic [1:0]  width,
    input  wire logic        fault,
    // pins to the host, plus last word and edge count for the testbench
    output logic             cfg_status_b,
    output logic             cfg_done,
    output logic             init_done,
    output logic [31:0]      last_word,
    output int               edges
);
    logic        clk_q;
    int          por;
    int          falls;
    logic [31:0] keep;
    assign keep = (width == 2'h0) ? 32'h0000_00ff : (width == 2'h1) ? 32'h0000_ffff : '1;
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b || !cfg_req_b || fault) begin
            cfg_status_b <= 1'b0;
            cfg_done     <= 1'b0;
            init_done    <= 1'b0;
            por          <= 0;
            edges        <= 0;
            falls        <= 0;
        end else if (por < POR_DLY) begin
            por <= por + 1;
        end else begin
            cfg_status_b <= 1'b1;
            if (config_clock && !clk_q && !cfg_done) begin
                edges     <= edges + 1;
                last_word <= cfg_data & keep;
                if (edges + 1 == WORDS * ratio) cfg_done <= 1'b1;
            end
            if (cfg_done && clk_q && !config_clock) falls <= falls + 1;
            if (falls >= 2) init_done <= 1'b1;
        end
    end
    always @(posedge sys_clk) clk_q <= config_clock;
endmodule

// ==== tb/ppl_host_tb_top.sv ====
`timescale 1ns/1ps
module ppl_host_tb_top;
    logic        sys_clk   = 1'b0;
    logic        rst_b     = 1'b0;
    logic [7:0]  addr      = 8'h00;
    logic [31:0] wdata     = 32'h0;
    logic        wr_en     = 1'b0;
    logic        rd_en     = 1'b0;
    logic        fault     = 1'b0;
    logic [3:0]  cur_ratio = 4'h1;
    logic [1:0]  cur_width = 2'h0;
    logic [31:0] rdata, cfg_data, last_word;
    logic        irq, config_clock, cfg_req_b, cfg_status_b, cfg_done, init_done;
    int          edges;
    int          miscompares = 0;
    int          checked     = 0;
    always #10 sys_clk = ~sys_clk;
    ppl_host #(.STATUS_TIMEOUT(200)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
        .config_clock(config_clock), .cfg_data(cfg_data), .cfg_req_b(cfg_req_b),
        .cfg_status_b(cfg_status_b), .cfg_done(cfg_done), .init_done(init_done));
    ppl_dev_model #(.WORDS(2)) i_dev (.sys_clk(sys_clk), .rst_b(rst_b),
        .config_clock(config_clock), .cfg_data(cfg_data), .cfg_req_b(cfg_req_b),
        .ratio(cur_ratio), .width(cur_width), .fault(fault), .cfg_status_b(cfg_status_b),
        .cfg_done(cfg_done), .init_done(init_done), .last_word(last_word), .edges(edges));
    task automatic summarize;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask
    // polling leaves one idle cycle between reads, so reads are never back-to-back
    task automatic poll(input logic [7:0] a, input int b, input logic v);
        logic [31:0] d;
        // start from the opposite value so at least one read is made
        d = {32{~v}};
        for (int n = 0; n < 3000 && d[b] !== v; n++) rd(a, d);
        if (d[b] !== v) begin
            miscompares++;
            $display("BAD %0t wait on register %h ran out", $time, a);
            summarize();
        end
    endtask
    function automatic logic [3:0] exp_ratio(input logic [1:0] w, input logic dc, input logic sc);
        if (w == ppl_pkg::WIDTH_8) return dc ? 4'h2 : 4'h1;
        if (w == ppl_pkg::WIDTH_16) return dc ? 4'h4 : (sc ? 4'h2 : 4'h1);
        return dc ? 4'h8 : (sc ? 4'h4 : 4'h1);
    endfunction
    task automatic run_cfg(input logic [1:0] w, input logic dc, input logic sc, input logic ie);
        logic [31:0] d;
        logic [31:0] keep;
        keep = (w == 2'h0) ? 32'h0000_00ff : (w == 2'h1) ? 32'h0000_ffff : '1;
        cur_ratio <= exp_ratio(w, dc, sc);
        cur_width <= w;
        wr(ppl_pkg::REG_CTRL, {26'h0, 1'b0, sc, dc, w, 1'b1});
        rd(ppl_pkg::REG_STATUS, d);
        chk({28'h0, d[14:11]}, {28'h0, exp_ratio(w, dc, sc)}, "ratio");
        for (int k = 0; k < 2; k++) begin
            poll(ppl_pkg::REG_STATUS, 3, 1'b0);
            wr(ppl_pkg::REG_DATA, 32'h8421_c3a5 + k);
        end
        poll(ppl_pkg::REG_EVENT, ppl_pkg::EV_DONE, 1'b1);
        chk(edges, 2 * exp_ratio(w, dc, sc), "clocks per image");
        chk(last_word, 32'h8421_c3a6 & keep, "last word");
        chk({28'h0, config_clock, cfg_req_b, cfg_status_b, init_done}, 32'h7, "user pins");
        chk({31'h0, irq}, {31'h0, ie}, "irq raised");
        rd(ppl_pkg::REG_WORDS, d);
        chk(d, 32'h0000_0002, "words clocked");
        // need is raised by every drained word, so all three are cleared
        wr(ppl_pkg::REG_EVENT, 32'h0000_0007);
        rd(ppl_pkg::REG_EVENT, d);
        chk(d, 32'h0, "event cleared");
        chk({31'h0, irq}, 32'h0, "irq cleared");
        $display("test load w%0d d%0d s%0d done", w, dc, sc);
    endtask
    initial begin
        logic [31:0] d;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(ppl_pkg::REG_EVENT, d);
        chk(d, {26'h0, ppl_pkg::EV_RESET}, "event reset");
        rd(ppl_pkg::REG_WORDS, d);
        chk(d, ppl_pkg::WORDS_RESET, "words reset");
        wr(ppl_pkg::REG_MASK, 32'h0000_0007);
        wr(8'h3c, 32'h0);
        rd(ppl_pkg::REG_MASK, d);
        chk(d, 32'h0000_0007, "mask after unmapped write");
        $display("test registers done");
        for (int w = 0; w < 3; w++)
            for (int f = 0; f < 4; f++) run_cfg(w[1:0], f[1], f[0], 1'b1);
        // error only: done and need masked, so irq must stay low
        wr(ppl_pkg::REG_MASK, 32'h0000_0002);
        run_cfg(2'h1, 1'b0, 1'b1, 1'b0);
        cur_ratio <= 4'h1;
        cur_width <= 2'h2;
        wr(ppl_pkg::REG_CTRL, 32'h0000_0005);
        wr(ppl_pkg::REG_DATA, 32'h1234_5678);
        for (int n = 0; n < 3000 && edges == 0; n++) @(posedge sys_clk);
        chk({31'h0, edges != 0}, 32'h1, "first word clocked");
        fault <= 1'b1;
        @(posedge sys_clk);
        fault <= 1'b0;
        poll(ppl_pkg::REG_EVENT, ppl_pkg::EV_ERROR, 1'b1);
        chk({31'h0, cfg_done}, 32'h0, "no complete after fault");
        chk({31'h0, irq}, 32'h1, "error irq");
        $display("test fault done");
        wr(ppl_pkg::REG_CTRL, 32'h0000_0005);
        wr(ppl_pkg::REG_DATA, 32'h1234_5678);
        for (int n = 0; n < 3000 && edges == 0; n++) @(posedge sys_clk);
        chk({31'h0, edges != 0}, 32'h1, "word before abort");
        wr(ppl_pkg::REG_CTRL, 32'h0000_0020);
        // a word offered after abort must never reach the pins
        wr(ppl_pkg::REG_DATA, 32'h8765_4321);
        repeat (40) @(posedge sys_clk);
        rd(ppl_pkg::REG_WORDS, d);
        chk(d, 32'h0000_0001, "abort stops loading");
        $display("test abort done");
        summarize();
    end
endmodule
